// >>> verilog/psfp_pkg.sv
// Constants and types for the power switch fault protection block.
// Assumes one 20 MHz clock pclk and an APB master for software access.
// Notes on behaviour
// - Overcurrent turns FET off after delay; flag holds until input falls.
// - After overcurrent clears on input fall, next cycle switches normally.
// - Delayed overcurrent before short-circuit detection means overcurrent.
// - Short-circuit detection before delayed overcurrent means short-circuit.
// - Short-circuit turn-off uses the slowed drive setting.
// - Short-circuit latches FET off until input low for reset time.
// - Switch-die thermal trip enters hot diode emulation.
// - Driver thermal trip sits above the switch-die trip.
// - Driver trip disables aux regulator, negative rail and the FET.
// - No diode emulation while the driver trip is active.
// - Fault output low while either thermal trip is active.
// - Fault releases only when both thermal trips have cleared.
// - Driver trip clearing with die trip active resumes diode emulation.
// - Undervoltage lockout holds FET off regardless of input.
// - Undervoltage lockout drives fault output low.
// - Regulator and negative rail enable on lockout release.
// - Drive pin open detection only in continuous monitoring.
// - Open drive pin holds FET off and asserts fault.
// - Drive pin fault clears by itself when open condition goes.
// - Two-output mode: truth table per fault type, short-circuit drives both low.
// - Single-output mode: every fault drives fault output low.
// - Drive pin tied to aux rail sensed once; monitoring then off.
// - Temperature output held high during switch-die overtemperature.
package psfp_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  // Delays in ns, counts derived from the clock rate
  localparam int unsigned OC_OFF_DELAY_NS = 100;
  localparam int unsigned DI_DT_WINDOW_NS = 50;
  localparam int unsigned SC_RESET_LOW_NS = 1000;
  localparam int unsigned NS_PER_S = 1_000_000_000;

  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * (CLK_HZ / 1_000_000) + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned OC_OFF_CYC = ns_to_cyc(OC_OFF_DELAY_NS);
  localparam int unsigned WINDOW_CYC = ns_to_cyc(DI_DT_WINDOW_NS);
  localparam int unsigned SC_RESET_CYC = ns_to_cyc(SC_RESET_LOW_NS);
  localparam int unsigned CNT_W = 16;
  // Edges for a pin level to pass the sync and agreement filter
  localparam int unsigned SYNC_SETTLE = 4;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_FLAGS = 8'h08;

  // Control field positions
  localparam int unsigned CTRL_ONE_PIN = 0;
  localparam int unsigned CTRL_SW_EN = 1;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

  typedef enum logic [1:0] {
    PSFP_RUN,
    PSFP_OC_HOLD,
    PSFP_SC_LATCH
  } psfp_cur_type;

  typedef struct packed {
    logic oc_raw;
    logic sc_raw;
    logic die_hot;
    logic drv_hot;
    logic uv;
    logic pin_open;
    logic pin_tied5v;
  } psfp_sense_type;

  typedef struct packed {
    logic fault_n;
    logic overcurrent_flag_n;
    logic gate_on;
    logic slow_drive;
    logic diode_emulation;
    logic temp_hold_high;
    logic aux_en;
    logic neg_en;
  } psfp_drive_type;

  localparam int unsigned SENSE_W = $bits(psfp_sense_type);
endpackage

// >>> verilog/psfp_top.sv
// Fault protection controller: gating of the FET and fault reporting.
// Assumes comparator inputs and sw_in arrive asynchronously from pins.
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
module psfp_top #(
  parameter int unsigned SC_RESET_CYCLES = psfp_pkg::SC_RESET_CYC,
  parameter int unsigned OC_OFF_CYCLES = psfp_pkg::OC_OFF_CYC,
  parameter int unsigned WINDOW_CYCLES = psfp_pkg::WINDOW_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sw_in,
  input wire psfp_pkg::psfp_sense_type sense,
  input wire logic pin_cont_mon,
  output psfp_pkg::psfp_drive_type drive
);

  localparam int unsigned SYN_W = psfp_pkg::SENSE_W + 2;
  // Lockout assumed active at reset, so no false release edge follows it
  localparam psfp_pkg::psfp_sense_type SENSE_RST = '{uv: 1'b1,
                                                     default: 1'b0};
  localparam logic [SYN_W-1:0] SYN_RST = {2'b00, SENSE_RST};

  // Three-stage sync, a change accepted when stages two and three agree
  logic [SYN_W-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
  logic [SYN_W-1:0] raw;

  assign raw = {sw_in, pin_cont_mon, sense};

  always_comb begin
    filt_nxt = filt_r;
    for (int i = 0; i < SYN_W; i++) begin
      if (s2_r[i] == s3_r[i]) begin
        filt_nxt[i] = s3_r[i];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= SYN_RST;
      s2_r <= SYN_RST;
      s3_r <= SYN_RST;
      filt_r <= SYN_RST;
    end else if (clk_en) begin
      s1_r <= raw;
      s2_r <= s1_r;
      s3_r <= s2_r;
      filt_r <= filt_nxt;
    end
  end

  psfp_pkg::psfp_sense_type sn;
  logic in_s, cont_s;
  assign sn = filt_r[psfp_pkg::SENSE_W-1:0];
  assign cont_s = filt_r[psfp_pkg::SENSE_W];
  assign in_s = filt_r[psfp_pkg::SENSE_W+1];

  // Current fault state machine with delay and window counters
  psfp_pkg::psfp_cur_type cur_r, cur_nxt;
  logic [psfp_pkg::CNT_W-1:0] win_r, win_nxt, off_r, off_nxt;
  logic [psfp_pkg::CNT_W-1:0] low_r, low_nxt;
  logic oc_del_r, oc_del_nxt, gate_off_r, gate_off_nxt;

  always_comb begin
    cur_nxt = cur_r;
    win_nxt = win_r;
    off_nxt = off_r;
    low_nxt = low_r;
    oc_del_nxt = oc_del_r;
    gate_off_nxt = gate_off_r;
    // Overcurrent detection delayed by the di/dt window
    if (!sn.oc_raw) begin
      win_nxt = '0;
      oc_del_nxt = 1'b0;
    end else if (win_r >= psfp_pkg::CNT_W'(WINDOW_CYCLES)) begin
      oc_del_nxt = 1'b1;
    end else begin
      win_nxt = win_r + 1'b1;
    end
    unique case (cur_r)
      psfp_pkg::PSFP_RUN: begin
        gate_off_nxt = 1'b0;
        off_nxt = '0;
        if (sn.sc_raw && !oc_del_r) begin
          cur_nxt = psfp_pkg::PSFP_SC_LATCH;
          low_nxt = '0;
        end else if (oc_del_r && in_s) begin
          cur_nxt = psfp_pkg::PSFP_OC_HOLD;
        end
      end
      psfp_pkg::PSFP_OC_HOLD: begin
        // Off after the turn-off delay, flag held until input falls
        if (off_r >= psfp_pkg::CNT_W'(OC_OFF_CYCLES)) begin
          gate_off_nxt = 1'b1;
        end else begin
          off_nxt = off_r + 1'b1;
        end
        if (!in_s) begin
          cur_nxt = psfp_pkg::PSFP_RUN;
          gate_off_nxt = 1'b0;
        end
      end
      psfp_pkg::PSFP_SC_LATCH: begin
        gate_off_nxt = 1'b1;
        if (in_s) begin
          low_nxt = '0;
        end else if (low_r >= psfp_pkg::CNT_W'(SC_RESET_CYCLES)) begin
          cur_nxt = psfp_pkg::PSFP_RUN;
          gate_off_nxt = 1'b0;
        end else begin
          low_nxt = low_r + 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_r <= psfp_pkg::PSFP_RUN;
      win_r <= '0;
      off_r <= '0;
      low_r <= '0;
      oc_del_r <= 1'b0;
      gate_off_r <= 1'b0;
    end else if (clk_en) begin
      cur_r <= cur_nxt;
      win_r <= win_nxt;
      off_r <= off_nxt;
      low_r <= low_nxt;
      oc_del_r <= oc_del_nxt;
      gate_off_r <= gate_off_nxt;
    end
  end

  // Undervoltage edge, supplies enable and drive pin strap capture
  logic uv_prev_r, uv_prev_nxt, sup_en_r, sup_en_nxt;
  logic strap_done_r, strap_done_nxt, tied_r, tied_nxt;
  logic [2:0] settle_r, settle_nxt;

  always_comb begin
    uv_prev_nxt = sn.uv;
    sup_en_nxt = sup_en_r;
    strap_done_nxt = strap_done_r;
    tied_nxt = tied_r;
    settle_nxt = settle_r;
    if (!strap_done_r) begin
      // Sense the strap once, only after the pin sync has filled
      if (settle_r == 3'(psfp_pkg::SYNC_SETTLE)) begin
        tied_nxt = sn.pin_tied5v;
        strap_done_nxt = 1'b1;
      end else begin
        settle_nxt = settle_r + 3'h1;
      end
    end
    if (uv_prev_r && !sn.uv) begin
      sup_en_nxt = 1'b1;
    end else if (sn.uv) begin
      sup_en_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uv_prev_r <= 1'b1;
      sup_en_r <= 1'b0;
      strap_done_r <= 1'b0;
      tied_r <= 1'b0;
      settle_r <= 3'h0;
    end else if (clk_en) begin
      settle_r <= settle_nxt;
      uv_prev_r <= uv_prev_nxt;
      sup_en_r <= sup_en_nxt;
      strap_done_r <= strap_done_nxt;
      tied_r <= tied_nxt;
    end
  end

  // Fault classification
  logic pin_fault, thermal, oc_act, sc_act, other_fault;
  logic die_only, one_pin, sw_en;
  assign pin_fault = cont_s && !tied_r && strap_done_r &&
                     sn.pin_open;
  assign thermal = sn.die_hot || sn.drv_hot;
  // Driver trip overrides diode emulation; it resumes when it clears
  assign die_only = sn.die_hot && !sn.drv_hot;
  assign oc_act = (cur_r == psfp_pkg::PSFP_OC_HOLD);
  assign sc_act = (cur_r == psfp_pkg::PSFP_SC_LATCH);
  assign other_fault = sn.uv || thermal || pin_fault;

  // Control and status registers
  logic [31:0] ctrl_r, ctrl_nxt, prdata_r, prdata_nxt;
  logic wr_acc, rd_acc, hit;

  assign one_pin = ctrl_r[psfp_pkg::CTRL_ONE_PIN];
  assign sw_en = ctrl_r[psfp_pkg::CTRL_SW_EN];
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign hit = (paddr == psfp_pkg::ADDR_CTRL) ||
               (paddr == psfp_pkg::ADDR_STATUS) ||
               (paddr == psfp_pkg::ADDR_FLAGS);

  always_comb begin
    ctrl_nxt = ctrl_r;
    prdata_nxt = prdata_r;
    if (wr_acc && paddr == psfp_pkg::ADDR_CTRL) begin
      ctrl_nxt = pwdata;
    end
    if (rd_acc) begin
      unique case (paddr)
        psfp_pkg::ADDR_CTRL: prdata_nxt = ctrl_r;
        psfp_pkg::ADDR_STATUS:
          prdata_nxt = {24'h00_0000, 1'b0, sn};
        psfp_pkg::ADDR_FLAGS:
          prdata_nxt = {26'h000_0000, tied_r, sup_en_r, pin_fault,
                        thermal, sc_act, oc_act};
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= psfp_pkg::CTRL_RESET;
      prdata_r <= 32'h0000_0000;
    end else if (clk_en) begin
      ctrl_r <= ctrl_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Output stage, registered
  psfp_pkg::psfp_drive_type drv_r, drv_nxt;
  logic hold_off;

  assign hold_off = sn.uv || sn.drv_hot || pin_fault || gate_off_r ||
                    !sw_en;

  always_comb begin
    drv_nxt.diode_emulation = die_only && !hold_off;
    drv_nxt.gate_on = !hold_off && !die_only && in_s;
    drv_nxt.slow_drive = sc_act;
    drv_nxt.temp_hold_high = sn.die_hot;
    drv_nxt.aux_en = sup_en_r && !sn.drv_hot;
    drv_nxt.neg_en = sup_en_r && !sn.drv_hot;
    if (one_pin) begin
      drv_nxt.fault_n = !(other_fault || oc_act || sc_act);
      drv_nxt.overcurrent_flag_n = 1'b1;
    end else begin
      drv_nxt.fault_n = !(other_fault || sc_act);
      drv_nxt.overcurrent_flag_n = !(oc_act || sc_act);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_r <= '{fault_n: 1'b0, overcurrent_flag_n: 1'b1,
                 default: 1'b0};
    end else if (clk_en) begin
      drv_r <= drv_nxt;
    end
  end

  assign drive = drv_r;

endmodule

// >>> tb/psfp_sva.sv
// Checker for the fault protection top ports.
// Assumes clk_en is held high by the bench.
`timescale 1ns/100ps
module psfp_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sw_in,
  input wire logic pin_cont_mon,
  input wire psfp_pkg::psfp_sense_type sense,
  input wire psfp_pkg::psfp_drive_type drive
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Eight edges cover sync, filter and output register
  sequence s_uv;
    sense.uv [*8];
  endsequence
  sequence s_drv;
    sense.drv_hot [*8];
  endsequence
  sequence s_die;
    (sense.die_hot && !sense.drv_hot && !sense.uv) [*8];
  endsequence
  sequence s_open;
    (sense.pin_open && pin_cont_mon && !sense.pin_tied5v) [*8];
  endsequence
  AST_UV_OFF: assert property (s_uv |-> !drive.gate_on)
    else $error("gate on in lockout");
  AST_UV_FLT: assert property (s_uv |-> !drive.fault_n)
    else $error("no fault in lockout");
  AST_HOT_FLT: assert property (
    (sense.die_hot || sense.drv_hot) [*8] |-> !drive.fault_n)
    else $error("no fault when hot");
  AST_DRV_OFF: assert property (
    s_drv |-> !drive.aux_en && !drive.neg_en && !drive.gate_on)
    else $error("supplies on in driver trip");
  AST_DRV_NODE: assert property (s_drv |-> !drive.diode_emulation)
    else $error("emulation in driver trip");
  AST_DIE_DE: assert property (s_die |-> drive.diode_emulation)
    else $error("no emulation when die hot");
  AST_OPEN: assert property (
    s_open |-> !drive.fault_n && !drive.gate_on)
    else $error("open pin not handled");
  AST_OC_OFF: assert property (
    $fell(drive.overcurrent_flag_n) |-> ##[0:4] !drive.gate_on)
    else $error("gate stays on after overcurrent");
  AST_OC_CLR: assert property (
    !sw_in [*8] |-> drive.overcurrent_flag_n || !drive.fault_n)
    else $error("overcurrent flag held with input low");
endmodule
bind psfp_top psfp_sva u_sva (.pclk(pclk), .presetn(presetn),
  .sw_in(sw_in), .pin_cont_mon(pin_cont_mon), .sense(sense),
  .drive(drive));

// >>> tb/psfp_ctl_model.sv
// Controller model: drives the switch input, reads the fault pins.
// Assumes it shares the clock of the block.
`timescale 1ns/100ps
module psfp_ctl_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [7:0] rst_len,
  input wire logic fault_n,
  input wire logic overcurrent_flag_n,
  output logic sw_in
);
  logic [7:0] cnt_r;
  logic f_r;
  logic o_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 8'h00;
      f_r <= 1'b1;
      o_r <= 1'b1;
      sw_in <= 1'b0;
    end else begin
      f_r <= fault_n;
      o_r <= overcurrent_flag_n;
      if (f_r && !fault_n) begin
        cnt_r <= rst_len;
        sw_in <= 1'b0;
      end else if (o_r && !overcurrent_flag_n) begin
        cnt_r <= 8'h03;
        sw_in <= 1'b0;
      end else if (cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
      end else begin
        sw_in <= run;
      end
    end
  end
endmodule

// >>> tb/tb.sv
// Self-checking bench for the fault protection top.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps
module tb;
  localparam int unsigned SCR = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic sw_in;
  logic run = 1'b0;
  logic look = 1'b0;
  logic pin_cont_mon = 1'b1;
  logic [7:0] rst_len = 8'h10;
  logic [15:0] de;
  psfp_pkg::psfp_sense_type sense = 7'h04;
  psfp_pkg::psfp_drive_type drive;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  integer seed = 32'h2deb;
  logic [32:0] rd_q[$];
  logic [15:0] dv_q[$];
  always #25 pclk = ~pclk;
  psfp_top #(.SC_RESET_CYCLES(SCR)) DUT (.pclk(pclk), .presetn(presetn),
    .clk_en(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sw_in(sw_in), .sense(sense),
    .pin_cont_mon(pin_cont_mon), .drive(drive));
  psfp_ctl_model u_ctl (.pclk(pclk), .presetn(presetn), .run(run),
    .rst_len(rst_len), .fault_n(drive.fault_n),
    .overcurrent_flag_n(drive.overcurrent_flag_n), .sw_in(sw_in));
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite)
      chk({pslverr, prdata}, rd_q.pop_front());
    if (look) begin
      de = dv_q.pop_front();
      chk({25'h0, drive & de[15:8]}, {25'h0, de[7:0]});
    end
    if (cyc == 20000) begin
      num_errors++;
      tally_and_finish;
    end
  end
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    rd_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic expd(input logic [7:0] m, input logic [7:0] v);
    dv_q.push_back({m, v});
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Waits on negedge so the drive update has landed
  task automatic wlow(input int b);
    repeat (30) if (drive[b] !== 1'b0) @(negedge pclk);
  endtask
  initial begin
    wt(3);
    presetn <= 1'b1;
    rst_len <= 8'(SCR + 8) + 8'($random(seed) & 3);
    rd(8'h00, {1'b0, psfp_pkg::CTRL_RESET});
    rd(8'h0c, 33'h1_0000_0000);
    wt(10);
    expd(8'hc3, 8'h40);
    sense.uv <= 1'b0;
    run <= 1'b1;
    wt(40);
    expd(8'he3, 8'he3);
    sense.uv <= 1'b1;
    wt(10);
    expd(8'ha0, 8'h00);
    sense.uv <= 1'b0;
    sense.die_hot <= 1'b1;
    wt(rst_len + 15);
    expd(8'ha8, 8'h08);
    sense.drv_hot <= 1'b1;
    wt(10);
    expd(8'hab, 8'h00);
    sense.drv_hot <= 1'b0;
    wt(10);
    expd(8'h88, 8'h08);
    sense.die_hot <= 1'b0;
    wt(rst_len + 15);
    expd(8'ha8, 8'ha0);
    sense.pin_open <= 1'b1;
    pin_cont_mon <= 1'b0;
    wt(10);
    expd(8'ha0, 8'ha0);
    pin_cont_mon <= 1'b1;
    wt(10);
    expd(8'ha0, 8'h00);
    sense.pin_open <= 1'b0;
    wt(rst_len + 15);
    expd(8'ha0, 8'ha0);
    sense.oc_raw <= 1'b1;
    wlow(6);
    expd(8'hc0, 8'h80);
    sense.oc_raw <= 1'b0;
    wt(20);
    expd(8'he0, 8'he0);
    apb(1'b1, 8'h00, 32'h3);
    sense.oc_raw <= 1'b1;
    wlow(7);
    expd(8'h80, 8'h00);
    sense.oc_raw <= 1'b0;
    wt(rst_len + 15);
    apb(1'b1, 8'h00, 32'h2);
    sense.oc_raw <= 1'b1;
    sense.sc_raw <= 1'b1;
    wlow(7);
    expd(8'hd0, 8'h10);
    sense.oc_raw <= 1'b0;
    sense.sc_raw <= 1'b0;
    wt(rst_len + 20);
    expd(8'he0, 8'he0);
    tally_and_finish;
  end
endmodule
